// *** pkg/camsc_defines.vh ***
// camsc_defines.vh: constants for the cam signal conditioning block
// assumes inclusion by bare name from the core files
`ifndef CAMSC_DEFINES_VH
`define CAMSC_DEFINES_VH
// ************************************************************
// register offsets (word addresses on the plain port)
// ************************************************************
`define CAMSC_ADDR_W        4
`define CAMSC_OFS_CTRL      4'h0
`define CAMSC_OFS_SHIFT     4'h1
`define CAMSC_OFS_STRETCH   4'h2
`define CAMSC_OFS_STATUS    4'h3
// ************************************************************
// control fields
// ************************************************************
`define CAMSC_CTRL_AUTOCLR  0
`define CAMSC_CTRL_SHIFT_ON 1
`define CAMSC_CTRL_STR_ON   2
`define CAMSC_CTRL_CHOICE   3
`define CAMSC_CTRL_GATE     4
`define CAMSC_CTRL_ENCODER  5
`define CAMSC_CTRL_RST      6'h00
// ************************************************************
// status fields and codes
// ************************************************************
`define CAMSC_CNT_W         8
`define CAMSC_CNT_RST       8'h01
`define CAMSC_ST_CRANK      0
`define CAMSC_ST_PH1        1
`define CAMSC_ST_PH2        2
`define CAMSC_ST_PAT_LO     3
`define CAMSC_RUN_STALLED   2'h0
`define CAMSC_RUN_CRANKING  2'h1
`define CAMSC_RUN_RUNNING   2'h2
`define CAMSC_PAT_NORMAL    2'h0
`define CAMSC_PAT_ERROR     2'h1
`define CAMSC_PAT_HIGH      2'h2
`define CAMSC_PAT_LOW       2'h3
`endif

// *** core/camsc_shift.v ***
// camsc_shift.v: offset stage, moves a cam pulse by a count of crank teeth
// assumes synchronised inputs and one-cycle crank edge pulses
`include "camsc_defines.vh"
module camsc_shift (
  input  wire                    sys_clk,
  input  wire                    rst,
  input  wire                    clk_en,
  input  wire                    enable,
  input  wire [`CAMSC_CNT_W-1:0] teeth,
  input  wire                    cam_in,
  input  wire                    cam_rise,
  input  wire                    crank_rise,
  input  wire                    crank_fall,
  output wire                    cam_out
);
  reg [`CAMSC_CNT_W-1:0] count_r;
  reg                    armed_r;
  reg                    ready_r;
  reg                    pulse_r;

  assign cam_out = enable ? pulse_r : cam_in;

  always @(posedge sys_clk) begin
    if (rst) begin
      count_r <= {`CAMSC_CNT_W{1'b0}};
      armed_r <= 1'b0;
      ready_r <= 1'b0;
      pulse_r <= 1'b0;
    end else if (clk_en) begin
      if (pulse_r && crank_rise)
        pulse_r <= 1'b0;
      if (cam_rise) begin
        count_r <= {`CAMSC_CNT_W{1'b0}};
        armed_r <= 1'b1;
        ready_r <= (teeth == {`CAMSC_CNT_W{1'b0}});
      end else if (armed_r && !ready_r && crank_rise) begin
        count_r <= count_r + 1'b1;
        if (count_r + 1'b1 == teeth)
          ready_r <= 1'b1;
      end else if (ready_r && crank_fall) begin
        pulse_r <= 1'b1;
        ready_r <= 1'b0;
        armed_r <= 1'b0;
      end
    end
  end
endmodule

// *** core/camsc_stretch.v ***
// camsc_stretch.v: extension stage, holds a pulse for a count of crank teeth
// assumes synchronised inputs and one-cycle crank edge pulses
`include "camsc_defines.vh"
module camsc_stretch (
  input  wire                    sys_clk,
  input  wire                    rst,
  input  wire                    clk_en,
  input  wire                    enable,
  input  wire [`CAMSC_CNT_W-1:0] teeth,
  input  wire                    cam_in,
  input  wire                    crank_rise,
  output wire                    cam_out
);
  reg                    prev_r;
  reg [`CAMSC_CNT_W-1:0] left_r;
  reg                    hold_r;
  wire                   rise = cam_in & ~prev_r;

  assign cam_out = enable ? hold_r : cam_in;

  always @(posedge sys_clk) begin
    if (rst) begin
      prev_r <= 1'b0;
      left_r <= {`CAMSC_CNT_W{1'b0}};
      hold_r <= 1'b0;
    end else if (clk_en) begin
      prev_r <= cam_in;
      if (rise) begin
        left_r <= teeth;
        hold_r <= (teeth != {`CAMSC_CNT_W{1'b0}});
      end else if (hold_r && crank_rise) begin
        left_r <= left_r - 1'b1;
        if (left_r == {{(`CAMSC_CNT_W-1){1'b0}}, 1'b1})
          hold_r <= 1'b0;
      end
    end
  end
endmodule

// *** core/camsc_top.v ***
// Contract
// - auto-clear on: clear tracker faults while engine reports cranking.
// - gap and extra-tooth patterns use the chosen phase input as reference.
// - encoder patterns use the chosen phase input to gate the index.
// - offset stage counts crank teeth from each phase rising edge.
// - offset output rises on crank fall after the configured rising edges.
// - offset output falls on the next crank rising edge.
// - offset stage disabled passes the selected phase signal unchanged.
// - offset stage output feeds the extension stage input.
// - extension holds high for configured teeth from its input rising edge.
// - extension output goes to index gate or straight to tracker.
// - extension stage disabled passes its input unchanged.
// - in sync on gap patterns, classify phase at each wheel feature.
// - the error classification never drops synchronisation.
// - gated mode ANDs index pulse with conditioned phase signal.
// - ungated mode forwards the index pulse regardless of phase.
// - readable indicators of crank and both phase input levels.
// - report cranking when speed is above stall and at or below run limit.
// - fault clearing resets all four tracker fault flags together.
//
// camsc_top.v: cam signal conditioning in front of a position tracker
// assumes asynchronous sensor pins, a same-clock tracker and register master
`include "camsc_defines.vh"
module camsc_top (
  input  wire                     sys_clk,
  input  wire                     rst,
  input  wire                     clk_en,
  input  wire [`CAMSC_ADDR_W-1:0] reg_addr,
  input  wire [7:0]               reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [7:0]               reg_rdata,
  input  wire                     crank_pin,
  input  wire                     first_phase_input,
  input  wire                     second_phase_input,
  input  wire                     encoder_index_pulse,
  input  wire [15:0]              crank_rpm,
  input  wire [15:0]              stall_rpm_limit,
  input  wire [15:0]              run_rpm_limit,
  input  wire                     tracker_in_sync,
  input  wire                     wheel_feature,
  output reg  [1:0]               engine_run_state,
  output reg                      tracker_phase,
  output reg                      tracker_index,
  output reg                      fault_clear,
  output wire                     short_tooth_fault_clr,
  output wire                     absent_gap_fault_clr,
  output wire                     absent_index_fault_clr,
  output wire                     absent_extra_tooth_fault_clr,
  output reg  [1:0]               phase_pattern_status
);
// ************************************************************
// registers
// ************************************************************
  reg  [5:0]              ctrl_r;
  reg  [`CAMSC_CNT_W-1:0] phase_shift_teeth;
  reg  [`CAMSC_CNT_W-1:0] phase_stretch_teeth;
  reg                     manual_clr_r;
  wire auto_fault_clear_on_start = ctrl_r[`CAMSC_CTRL_AUTOCLR];
  wire phase_shift_on     = ctrl_r[`CAMSC_CTRL_SHIFT_ON];
  wire phase_stretch_on   = ctrl_r[`CAMSC_CTRL_STR_ON];
  wire phase_input_choice = ctrl_r[`CAMSC_CTRL_CHOICE];
  wire index_gate_mode    = ctrl_r[`CAMSC_CTRL_GATE];
  wire encoder_pattern    = ctrl_r[`CAMSC_CTRL_ENCODER];
  wire [7:0] status_w;

  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r              <= `CAMSC_CTRL_RST;
      phase_shift_teeth   <= `CAMSC_CNT_RST;
      phase_stretch_teeth <= `CAMSC_CNT_RST;
      manual_clr_r        <= 1'b0;
      reg_rdata           <= 8'h00;
    end else if (clk_en) begin
      manual_clr_r <= 1'b0;
      reg_rdata    <= 8'h00;
      if (reg_wr) begin
        case (reg_addr)
          `CAMSC_OFS_CTRL:    ctrl_r <= reg_wdata[5:0];
          `CAMSC_OFS_SHIFT:   phase_shift_teeth <= reg_wdata;
          `CAMSC_OFS_STRETCH: phase_stretch_teeth <= reg_wdata;
          `CAMSC_OFS_STATUS:  manual_clr_r <= reg_wdata[7];
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `CAMSC_OFS_CTRL:    reg_rdata <= {2'h0, ctrl_r};
          `CAMSC_OFS_SHIFT:   reg_rdata <= phase_shift_teeth;
          `CAMSC_OFS_STRETCH: reg_rdata <= phase_stretch_teeth;
          `CAMSC_OFS_STATUS:  reg_rdata <= status_w;
          default:            reg_rdata <= 8'h00;
        endcase
      end
    end
  end
// ************************************************************
// pin synchronisers and edge detection
// ************************************************************
  reg [2:0] meta_r;
  reg [2:0] sync_r;
  reg [2:0] last_r;
  reg       idx_meta_r;
  reg       idx_sync_r;

  always @(posedge sys_clk) begin
    if (rst) begin
      meta_r     <= 3'h0;
      sync_r     <= 3'h0;
      last_r     <= 3'h0;
      idx_meta_r <= 1'b0;
      idx_sync_r <= 1'b0;
    end else if (clk_en) begin
      meta_r     <= {second_phase_input, first_phase_input, crank_pin};
      sync_r     <= meta_r;
      last_r     <= sync_r;
      idx_meta_r <= encoder_index_pulse;
      idx_sync_r <= idx_meta_r;
    end
  end

  wire crank_rise = sync_r[0] & ~last_r[0];
  wire crank_fall = ~sync_r[0] & last_r[0];
  wire sel_phase  = phase_input_choice ? sync_r[2] : sync_r[1];
  wire sel_last   = phase_input_choice ? last_r[2] : last_r[1];
  wire sel_rise   = sel_phase & ~sel_last;
// ************************************************************
// offset and extension chain
// ************************************************************
  wire shifted;
  wire stretched;

  camsc_shift u_shift (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .enable     (phase_shift_on),
    .teeth      (phase_shift_teeth),
    .cam_in     (sel_phase),
    .cam_rise   (sel_rise),
    .crank_rise (crank_rise),
    .crank_fall (crank_fall),
    .cam_out    (shifted)
  );

  camsc_stretch u_stretch (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .enable     (phase_stretch_on),
    .teeth      (phase_stretch_teeth),
    .cam_in     (shifted),
    .crank_rise (crank_rise),
    .cam_out    (stretched)
  );
// ************************************************************
// routing and index gating
// ************************************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      tracker_phase <= 1'b0;
      tracker_index <= 1'b0;
    end else if (clk_en) begin
      tracker_phase <= encoder_pattern ? 1'b0 : stretched;
      if (!encoder_pattern)
        tracker_index <= 1'b0;
      else if (index_gate_mode)
        tracker_index <= idx_sync_r & stretched;
      else
        tracker_index <= idx_sync_r;
    end
  end
// ************************************************************
// engine state and fault clearing
// ************************************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      engine_run_state <= `CAMSC_RUN_STALLED;
      fault_clear      <= 1'b0;
    end else if (clk_en) begin
      if (crank_rpm > run_rpm_limit)
        engine_run_state <= `CAMSC_RUN_RUNNING;
      else if (crank_rpm > stall_rpm_limit)
        engine_run_state <= `CAMSC_RUN_CRANKING;
      else
        engine_run_state <= `CAMSC_RUN_STALLED;
      fault_clear <= manual_clr_r | (auto_fault_clear_on_start &
                     (engine_run_state == `CAMSC_RUN_CRANKING));
    end
  end

  assign short_tooth_fault_clr        = fault_clear;
  assign absent_gap_fault_clr         = fault_clear;
  assign absent_index_fault_clr       = fault_clear;
  assign absent_extra_tooth_fault_clr = fault_clear;
// ************************************************************
// phase pattern classification
// ************************************************************
  reg       seen_r;
  reg       prev_lvl_r;
  reg       alt_ok_r;
  reg       any_hi_r;
  reg       any_lo_r;
  reg [1:0] pat_nxt;

  always @* begin
    if (!any_lo_r)
      pat_nxt = `CAMSC_PAT_HIGH;
    else if (!any_hi_r)
      pat_nxt = `CAMSC_PAT_LOW;
    else if (alt_ok_r)
      pat_nxt = `CAMSC_PAT_NORMAL;
    else
      pat_nxt = `CAMSC_PAT_ERROR;
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      seen_r     <= 1'b0;
      prev_lvl_r <= 1'b0;
      alt_ok_r   <= 1'b1;
      any_hi_r   <= 1'b0;
      any_lo_r   <= 1'b0;
      phase_pattern_status <= `CAMSC_PAT_LOW;
    end else if (clk_en) begin
      if (!tracker_in_sync || encoder_pattern) begin
        seen_r   <= 1'b0;
        alt_ok_r <= 1'b1;
        any_hi_r <= 1'b0;
        any_lo_r <= 1'b0;
      end else if (wheel_feature) begin
        seen_r     <= 1'b1;
        prev_lvl_r <= stretched;
        any_hi_r   <= any_hi_r | stretched;
        any_lo_r   <= any_lo_r | ~stretched;
        if (seen_r)
          alt_ok_r <= alt_ok_r & (stretched != prev_lvl_r);
      end else if (seen_r) begin
        phase_pattern_status <= pat_nxt;
      end
    end
  end
// ************************************************************
// status word
// ************************************************************
  assign status_w = {2'h0, sync_r[0], phase_pattern_status, sync_r[2], sync_r[1],
                     engine_run_state == `CAMSC_RUN_CRANKING};
endmodule

// *** testbench/camsc_props.sv ***
// camsc_props.sv: assertions on the cam conditioning top ports
// assumes bind to camsc_top with clk_en held high
module camsc_props (
  input wire        sys_clk,
  input wire        rst,
  input wire        clk_en,
  input wire [3:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        first_phase_input,
  input wire        second_phase_input,
  input wire        encoder_index_pulse,
  input wire [15:0] crank_rpm,
  input wire [15:0] stall_rpm_limit,
  input wire [15:0] run_rpm_limit,
  input wire [1:0]  engine_run_state,
  input wire        tracker_phase,
  input wire        tracker_index,
  input wire        fault_clear,
  input wire        short_tooth_fault_clr,
  input wire        absent_gap_fault_clr,
  input wire        absent_index_fault_clr,
  input wire        absent_extra_tooth_fault_clr
);
  timeunit 1ns;
  timeprecision 100ps;
  reg  [5:0] ctl_r;
  reg  [2:0] quiet_r;
  wire       ctl_wr = clk_en && reg_wr && reg_addr == 4'h0;
  wire       calm = quiet_r == 3'h7;
  wire       sel = ctl_r[3] ? second_phase_input : first_phase_input;
  // ********************
  // control shadow and settle count
  // ********************
  always @(posedge sys_clk) begin
    if (rst || ctl_wr) quiet_r <= 3'h0;
    else if (!calm) quiet_r <= quiet_r + 3'h1;
    if (rst) ctl_r <= 6'h00;
    else if (ctl_wr) ctl_r <= reg_wdata[5:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_clr_copies: assert property ({short_tooth_fault_clr,
    absent_gap_fault_clr, absent_index_fault_clr,
    absent_extra_tooth_fault_clr} == {4{fault_clear}})
    else $error("fault clear copies differ");
  a_crank_state: assert property (crank_rpm > stall_rpm_limit &&
    crank_rpm < run_rpm_limit |=> engine_run_state == 2'h1)
    else $error("cranking not reported");
  a_stall_state: assert property (crank_rpm <= stall_rpm_limit
    |=> engine_run_state == 2'h0) else $error("stall not reported");
  a_auto_clear: assert property (ctl_r[0] &&
    engine_run_state == 2'h1 |=> fault_clear)
    else $error("no clear while cranking");
  a_phase_pass: assert property (calm && ctl_r[5:1] == 5'h00
    |-> tracker_phase == $past(sel, 3)) else $error("phase not passed");
  a_phase_quiet: assert property (calm && ctl_r[5]
    |-> !tracker_phase) else $error("phase out in encoder mode");
  a_index_off: assert property (calm && !ctl_r[5]
    |-> !tracker_index) else $error("index out in gap mode");
  a_index_pass: assert property (calm && ctl_r[5:4] == 2'h2
    |-> tracker_index == $past(encoder_index_pulse, 3))
    else $error("index not passed");
  a_index_gate: assert property (calm && ctl_r[5:4] == 2'h3 &&
    ctl_r[2:1] == 2'h0 |-> tracker_index ==
    ($past(encoder_index_pulse, 3) && $past(sel, 3)))
    else $error("index not gated");
endmodule
bind camsc_top camsc_props u_props (.*);

// *** testbench/camsc_sensor_model.sv ***
// camsc_sensor_model.sv: crank wheel stand-in for the phase conditioner
// assumes the bench drives phase and index levels itself
module camsc_sensor_model #(
  parameter int HALF = 10
) (
  input  wire logic sys_clk,
  input  wire logic run,
  output logic      crank_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial crank_pin = 1'b0;
  // ********************
  // crank teeth, still and low between runs
  // ********************
  always @(posedge sys_clk) begin
    if (!run || cnt == HALF - 1) cnt <= 0;
    else cnt <= cnt + 1;
    if (!run) crank_pin <= 1'b0;
    else if (cnt == HALF - 1) crank_pin <= !crank_pin;
  end
endmodule

// *** testbench/tb.sv ***
// tb.sv: directed bench for the cam conditioning block
// assumes the design files, the checker and the sensor model
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 10;
  logic        sys_clk = 0, rst = 1, clk_en = 1, run = 0, crank_pin;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        reg_wr = 0, reg_rd = 0, wheel_feature = 0;
  logic        first_phase_input = 0, second_phase_input = 0;
  logic        encoder_index_pulse = 0, tracker_in_sync = 0;
  logic [15:0] crank_rpm = 16'h0000;
  logic [15:0] stall_rpm_limit = 16'h0064, run_rpm_limit = 16'h00C8;
  logic [1:0]  engine_run_state, phase_pattern_status;
  logic        tracker_phase, tracker_index, fault_clear;
  logic        short_tooth_fault_clr, absent_gap_fault_clr;
  logic        absent_index_fault_clr, absent_extra_tooth_fault_clr;
  logic [15:0] spd [5] = '{16'h0032, 16'h0064, 16'h0096, 16'h00C8, 16'h00FA};
  logic [1:0]  est [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  logic [7:0]  gm [3] = '{8'h30, 8'h38, 8'h20};
  int          miscompares = 0, n_tests = 0;
  camsc_sensor_model #(.HALF(HALF)) u_sens (.sys_clk(sys_clk), .run(run),
    .crank_pin(crank_pin));
  camsc_top DUT (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  // ********************
  // tasks
  // ********************
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic feats(input logic [7:0] lv, input logic [1:0] e);
    tracker_in_sync <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      first_phase_input <= lv[k];
      cycles(6);
      wheel_feature <= 1'b1;
      cycles(1);
      wheel_feature <= 1'b0;
    end
    cycles(2);
    chk("pattern", phase_pattern_status, e);
    tracker_in_sync <= 1'b0;
    cycles(2);
  endtask
  task automatic meas(input bit s, input int ne, he, we);
    int n, h, w;
    logic p;
    n = 0;
    h = 0;
    w = 0;
    p = 1'b0;
    @(negedge crank_pin);
    cycles(HALF / 2);
    if (s) second_phase_input <= 1'b1;
    else first_phase_input <= 1'b1;
    for (int k = 0; k < 900 && (w == 0 || tracker_phase); k++) begin
      cycles(1);
      if (crank_pin && !p && w == 0) n++;
      else if (crank_pin && !p) h++;
      p = crank_pin;
      if (tracker_phase) w++;
    end
    chk("rises_before", n, ne);
    chk("rises_during", h, he);
    chk("width", w, we);
    first_phase_input <= 1'b0;
    second_phase_input <= 1'b0;
    cycles(6 * HALF);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    give_verdict;
  end
  // ********************
  // main sequence
  // ********************
  initial begin
    logic e;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(4'h1, 8'h01);
    wr(4'h4, 8'hFF);
    rchk(4'h4, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {second_phase_input, first_phase_input} <= i[1:0];
      cycles(4);
      rchk(4'h3, {3'h0, 2'h3, i[1:0], 1'b0});
    end
    {second_phase_input, first_phase_input} <= 2'h0;
    for (int i = 0; i < 5; i++) begin
      crank_rpm <= spd[i];
      cycles(2);
      chk("run_state", engine_run_state, est[i]);
    end
    wr(4'h0, 8'h01);
    crank_rpm <= 16'h0096;
    cycles(3);
    chk("clear", {fault_clear, absent_gap_fault_clr,
      absent_index_fault_clr, absent_extra_tooth_fault_clr,
      short_tooth_fault_clr}, 16'h001F);
    wr(4'h0, 8'h00);
    cycles(3);
    chk("clear_off", fault_clear, 1'b0);
    wr(4'h3, 8'h80);
    cycles(1);
    chk("manual_clear", fault_clear, 1'b1);
    cycles(1);
    chk("manual_end", fault_clear, 1'b0);
    feats(8'h15, 2'h0);
    feats(8'h0B, 2'h1);
    feats(8'h00, 2'h3);
    feats(8'hFF, 2'h2);
    run <= 1'b1;
    wr(4'h1, 8'h02);
    wr(4'h0, 8'h0A);
    meas(1, 2, 1, HALF);
    wr(4'h2, 8'h03);
    wr(4'h0, 8'h04);
    meas(0, 0, 3, HALF / 2 + 4 * HALF);
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h02);
    wr(4'h0, 8'h06);
    meas(0, 1, 2, 3 * HALF - 1);
    @(posedge crank_pin);
    cycles(3);
    rchk(4'h3, 8'h31);
    run <= 1'b0;
    foreach (gm[m]) begin
      wr(4'h0, gm[m]);
      for (int i = 0; i < 8; i++) begin
        {second_phase_input, first_phase_input, encoder_index_pulse} <= i[2:0];
        cycles(5);
        e = gm[m][3] ? i[2] : i[1];
        e = gm[m][4] ? e & i[0] : i[0];
        chk("index", tracker_index, e);
        chk("phase", tracker_phase, 1'b0);
      end
    end
    clk_en <= 1'b0;
    wr(4'h1, 8'h55);
    clk_en <= 1'b1;
    rchk(4'h1, 8'h01);
    give_verdict;
  end
endmodule
